// [rtl/fs_flash_seq.v]
// serial flash command sequencer: quad page program, security registers, deep sleep
// assumes host pins arrive asynchronously and sclk is at most an eighth of clk_i
//
// Behaviour
// - quad program frame: 32h, three address bytes on line 0, nibble data.
// - quad program buffers, wraps, checks protection and times like page program.
// - three 256-byte security registers selected by address bits 23-9.
// - secreg erase: 44h, 24-bit address, needs write latch, sector erase time.
// - write in progress reads 1 during secreg cycles, 0 after; status readable.
// - locked security registers ignore erase and program.
// - secreg program: 42h, address, 1 to 256 bytes, needs write latch.
// - secreg program cycle starts at select rise, lasts page program time.
// - secreg read: 48h, address, dummy byte in, data out on falling edges.
// - secreg read address increments per byte, wraps 1ffh to 000h.
// - deep sleep b9h; enter after sleep entry delay once select rises.
// - asleep, ignore everything except wake and signature read.
// - wake runs only if select rises right after eighth opcode bit or after the 24th address bit.
// - wake to standby at once, or after wake delay if asleep.
// - signature read abh returns byte repeatedly while clocked.
// - wake and signature read refused during a busy cycle, cycle undisturbed.
// - after power cycle the device is in standby.
// - deselect alone never enters deep sleep.
// - page data wraps within page; only last 256 bytes kept.
// - cycle end clears write in progress and write latch.
`default_nettype none
`include "fs_flash_map.vh"
module fs_flash_seq #(
    parameter [31:0] SE_CYC = (`FS_T_SECTOR_ERASE_NS + `FS_CLK_NS - 1) / `FS_CLK_NS,
    parameter [31:0] PP_CYC = (`FS_T_PAGE_PROGRAM_NS + `FS_CLK_NS - 1) / `FS_CLK_NS
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire sclk_i,
    input wire cs_b_i,
    input wire [3:0] serial_io_lines_i,
    output reg [3:0] serial_io_lines_o,
    output reg [3:0] serial_io_lines_oe_o,
    input wire quad_io_enable_bit_i,
    input wire [2:0] secreg_lock_bits_i,
    input wire wr_protect_i,
    output reg write_in_progress_bit_o,
    output reg write_latch_bit_o,
    output reg deep_sleep_o,
    output reg arr_valid_o,
    output reg [23:0] arr_addr_o,
    output reg [7:0] arr_data_o,
    input wire arr_ready_i
);
    localparam [31:0] DP_CYC = (`FS_T_SLEEP_ENTRY_NS + `FS_CLK_NS - 1) / `FS_CLK_NS;
    localparam [31:0] WK_CYC = (`FS_T_WAKE_NS + `FS_CLK_NS - 1) / `FS_CLK_NS;
    localparam [5:0] PH_CMD = 6'h01;
    localparam [5:0] PH_ADDR = 6'h02;
    localparam [5:0] PH_DUMMY = 6'h04;
    localparam [5:0] PH_DIN = 6'h08;
    localparam [5:0] PH_DOUT = 6'h10;
    localparam [5:0] PH_END = 6'h20;
    localparam [4:0] ST_STANDBY = 5'h01;
    localparam [4:0] ST_BUSY = 5'h02;
    localparam [4:0] ST_SLEEP_ENTRY = 5'h04;
    localparam [4:0] ST_SLEEP = 5'h08;
    localparam [4:0] ST_WAKE = 5'h10;
    localparam [2:0] K_ERASE = 3'h1;
    localparam [2:0] K_SECPROG = 3'h2;
    localparam [2:0] K_QUAD = 3'h4;

    reg [`FS_SYNC_W-1:0] sync1_ff;
    reg [`FS_SYNC_W-1:0] sync2_ff;
    reg sclk_d_ff;
    reg cs_d_ff;
    reg [5:0] ph_ff;
    reg [4:0] cnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] op_ff;
    reg [23:0] addr_ff;
    reg [7:0] ptr_ff;
    reg done_ff;
    reg [2:0] obit_ff;
    reg [255:0] mask_ff;
    reg [4:0] st_ff;
    reg [2:0] kind_ff;
    reg [23:0] timer_ff;
    reg [8:0] walk_ff;
    reg [2:0] lock_ff;
    reg [7:0] pg_buf [0:`FS_PAGE_WORDS-1];
    reg [7:0] sec_mem [0:`FS_SEC_WORDS-1];

    wire sclk_rise = sync2_ff[`FS_PIN_SCLK] & ~sclk_d_ff;
    wire sclk_fall = ~sync2_ff[`FS_PIN_SCLK] & sclk_d_ff;
    wire cs_rise = sync2_ff[`FS_PIN_CS] & ~cs_d_ff;
    wire cs_fall = ~sync2_ff[`FS_PIN_CS] & cs_d_ff;
    wire cs_low = ~sync2_ff[`FS_PIN_CS];
    wire [3:0] sio_s = sync2_ff[3:0];
    wire [7:0] nxt_op = {shift_ff[6:0], sio_s[0]};
    wire [23:0] nxt_addr = {addr_ff[22:0], sio_s[0]};
    wire is_quad = (op_ff == `FS_OP_QUAD_PAGE_PROGRAM);
    wire [7:0] din_byte = is_quad ? {shift_ff[3:0], sio_s} : {shift_ff[6:0], sio_s[0]};
    wire din_last = is_quad ? (cnt_ff == `FS_CNT_QUAD) : (cnt_ff == `FS_CNT_BYTE_LAST);
    wire [4:0] din_step = is_quad ? `FS_CNT_QUAD : `FS_CNT_ONE;
    // security register decode from the latched address
    wire sec_ok = (addr_ff[23:16] == `FS_SEC_TOP) && (addr_ff[11:9] == `FS_SEC_MID) &&
                  (addr_ff[15:12] >= `FS_SEC_REG1) && (addr_ff[15:12] <= `FS_SEC_REG3);
    wire [1:0] sec_sel = addr_ff[13:12] - 2'h1;
    wire sec_locked = lock_ff[sec_sel];
    wire in_standby = (st_ff == ST_STANDBY);
    wire in_sleep = (st_ff == ST_SLEEP);
    wire write_latch_bit = write_latch_bit_o;
    wire walking = (st_ff == ST_BUSY) && (walk_ff != `FS_WALK_END);
    wire [7:0] widx = walk_ff[7:0];
    wire wmask = mask_ff[widx];
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`FS_FIFO_W-1:0] fifo_out_data;
    wire fifo_out_ready = ~arr_valid_o | arr_ready_i;
    wire q_push = walking && (kind_ff == K_QUAD) && wmask;
    wire walk_adv = walking && (~q_push | fifo_in_ready);
    wire sec_we = walking && ((kind_ff == K_ERASE) || ((kind_ff == K_SECPROG) && wmask));
    wire [9:0] sec_widx = {sec_sel, widx};
    wire [9:0] sec_ridx = {sec_sel, addr_ff[7:0]};
    wire pg_we = ce_i && cs_low && sclk_rise && (ph_ff == PH_DIN) && din_last;
    reg [7:0] out_byte;
    reg cmd_ok;
    reg [5:0] cmd_ph;

    always @* begin
        out_byte = `FS_SIGNATURE;
        if (op_ff == `FS_OP_READ_STATUS) begin
            out_byte = {`FS_STATUS_PAD, write_latch_bit_o, write_in_progress_bit_o};
        end else if (op_ff == `FS_OP_SECREG_READ) begin
            out_byte = sec_ok ? sec_mem[sec_ridx] : `FS_ERASED;
        end
    end

    // opcode filter: busy and sleep admit only a narrow set
    always @* begin
        cmd_ok = 1'b0;
        cmd_ph = PH_END;
        case (nxt_op)
            `FS_OP_READ_STATUS: begin
                cmd_ok = ~in_sleep;
                cmd_ph = PH_DOUT;
            end
            `FS_OP_WAKE_SIGNATURE: begin
                cmd_ok = in_standby | in_sleep;
                cmd_ph = PH_ADDR;
            end
            `FS_OP_SET_WRITE_LATCH, `FS_OP_DEEP_SLEEP: begin
                cmd_ok = in_standby;
                cmd_ph = PH_END;
            end
            `FS_OP_QUAD_PAGE_PROGRAM: begin
                cmd_ok = in_standby & write_latch_bit & quad_io_enable_bit_i;
                cmd_ph = PH_ADDR;
            end
            `FS_OP_SECREG_ERASE, `FS_OP_SECREG_PROGRAM: begin
                cmd_ok = in_standby & write_latch_bit;
                cmd_ph = PH_ADDR;
            end
            `FS_OP_SECREG_READ: begin
                cmd_ok = in_standby;
                cmd_ph = PH_ADDR;
            end
            default: begin
                cmd_ok = 1'b0;
                cmd_ph = PH_END;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= `FS_SYNC_RST;
            sync2_ff <= `FS_SYNC_RST;
            sclk_d_ff <= 1'b1;
            cs_d_ff <= 1'b1;
        end else if (ce_i) begin
            sync1_ff <= {sclk_i, cs_b_i, serial_io_lines_i};
            sync2_ff <= sync1_ff;
            sclk_d_ff <= sync2_ff[`FS_PIN_SCLK];
            cs_d_ff <= sync2_ff[`FS_PIN_CS];
        end
    end

    always @(posedge clk_i) begin
        if (pg_we) begin
            pg_buf[ptr_ff] <= din_byte;
        end
        if (ce_i && sec_we) begin
            sec_mem[sec_widx] <= (kind_ff == K_ERASE) ? `FS_ERASED : (sec_mem[sec_widx] & pg_buf[widx]);
        end
    end

    // frame decoder, follows the host clock edges inside one select
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_ff <= PH_CMD;
            cnt_ff <= `FS_CNT_ZERO;
            shift_ff <= 8'h00;
            op_ff <= 8'h00;
            addr_ff <= 24'h000000;
            ptr_ff <= 8'h00;
            done_ff <= 1'b0;
            obit_ff <= 3'h0;
            mask_ff <= {256{1'b0}};
            serial_io_lines_o <= 4'h0;
            serial_io_lines_oe_o <= 4'h0;
        end else if (ce_i) begin
            if (cs_rise || cs_fall) begin
                ph_ff <= PH_CMD;
                cnt_ff <= `FS_CNT_ZERO;
                done_ff <= 1'b0;
                obit_ff <= 3'h0;
                serial_io_lines_oe_o <= 4'h0;
            end else if (cs_low && sclk_rise) begin
                case (ph_ff)
                    PH_CMD: begin
                        shift_ff <= nxt_op;
                        cnt_ff <= cnt_ff + `FS_CNT_ONE;
                        if (cnt_ff == `FS_CNT_BYTE_LAST) begin
                            op_ff <= nxt_op;
                            cnt_ff <= `FS_CNT_ZERO;
                            ph_ff <= cmd_ok ? cmd_ph : PH_END;
                            done_ff <= cmd_ok;
                        end
                    end
                    PH_ADDR: begin
                        addr_ff <= nxt_addr;
                        cnt_ff <= cnt_ff + `FS_CNT_ONE;
                        done_ff <= 1'b0;
                        if (cnt_ff == `FS_CNT_ADDR_LAST) begin
                            cnt_ff <= `FS_CNT_ZERO;
                            ptr_ff <= nxt_addr[7:0];
                            mask_ff <= {256{1'b0}};
                            if (op_ff == `FS_OP_SECREG_READ) begin
                                ph_ff <= PH_DUMMY;
                            end else if (op_ff == `FS_OP_SECREG_ERASE) begin
                                ph_ff <= PH_END;
                                done_ff <= 1'b1;
                            end else if (op_ff == `FS_OP_WAKE_SIGNATURE) begin
                                ph_ff <= PH_DOUT;
                                done_ff <= 1'b1;
                            end else begin
                                ph_ff <= PH_DIN;
                            end
                        end
                    end
                    PH_DUMMY: begin
                        cnt_ff <= cnt_ff + `FS_CNT_ONE;
                        if (cnt_ff == `FS_CNT_BYTE_LAST) begin
                            cnt_ff <= `FS_CNT_ZERO;
                            ph_ff <= PH_DOUT;
                        end
                    end
                    PH_DIN: begin
                        // quad: high nibble then low, line 3 carries the msb
                        shift_ff <= din_byte;
                        cnt_ff <= cnt_ff + din_step;
                        done_ff <= 1'b0;
                        if (din_last) begin
                            cnt_ff <= `FS_CNT_ZERO;
                            mask_ff[ptr_ff] <= 1'b1;
                            ptr_ff <= ptr_ff + 8'h01;
                            done_ff <= 1'b1;
                        end
                    end
                    PH_DOUT: begin
                        done_ff <= done_ff;
                    end
                    default: begin
                        done_ff <= 1'b0;
                    end
                endcase
            end else if (cs_low && sclk_fall && (ph_ff == PH_DOUT)) begin
                serial_io_lines_o[1] <= out_byte[`FS_OBIT_LAST - obit_ff];
                serial_io_lines_oe_o[1] <= 1'b1;
                obit_ff <= obit_ff + 3'h1;
                if ((obit_ff == `FS_OBIT_LAST) && (op_ff == `FS_OP_SECREG_READ)) begin
                    addr_ff[8:0] <= addr_ff[8:0] + `FS_ADDR_ONE;
                end
            end
        end
    end

    // operating state: standby, self-timed cycle, sleep entry, sleep, wake
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff <= ST_STANDBY;
            kind_ff <= K_ERASE;
            timer_ff <= `FS_TIMER_ZERO;
            walk_ff <= `FS_WALK_END;
            lock_ff <= 3'h0;
            write_in_progress_bit_o <= 1'b0;
            write_latch_bit_o <= 1'b0;
            deep_sleep_o <= 1'b0;
            arr_valid_o <= 1'b0;
            arr_addr_o <= 24'h000000;
            arr_data_o <= 8'h00;
        end else if (ce_i) begin
            lock_ff <= lock_ff | secreg_lock_bits_i;  // once set, stays set
            if (fifo_out_valid && fifo_out_ready) begin
                arr_valid_o <= 1'b1;
                arr_addr_o <= fifo_out_data[31:8];
                arr_data_o <= fifo_out_data[7:0];
            end else if (arr_ready_i) begin
                arr_valid_o <= 1'b0;
            end
            if (timer_ff != `FS_TIMER_ZERO) begin
                timer_ff <= timer_ff - `FS_TIMER_ONE;
            end
            if (walk_adv) begin
                walk_ff <= walk_ff + `FS_WALK_ONE;
            end
            case (st_ff)
                ST_STANDBY: begin
                    // only a completed sleep opcode sleeps; bare deselect does not
                    if (cs_rise && done_ff) begin
                        if (op_ff == `FS_OP_SET_WRITE_LATCH) begin
                            write_latch_bit_o <= 1'b1;
                        end else if (op_ff == `FS_OP_DEEP_SLEEP) begin
                            st_ff <= ST_SLEEP_ENTRY;
                            timer_ff <= DP_CYC[23:0];
                        end else if (op_ff == `FS_OP_SECREG_ERASE && sec_ok && !sec_locked) begin
                            st_ff <= ST_BUSY;
                            kind_ff <= K_ERASE;
                            timer_ff <= SE_CYC[23:0];
                            walk_ff <= 9'h000;
                            write_in_progress_bit_o <= 1'b1;
                        end else if (op_ff == `FS_OP_SECREG_PROGRAM && sec_ok && !sec_locked) begin
                            st_ff <= ST_BUSY;
                            kind_ff <= K_SECPROG;
                            timer_ff <= PP_CYC[23:0];
                            walk_ff <= 9'h000;
                            write_in_progress_bit_o <= 1'b1;
                        end else if (op_ff == `FS_OP_QUAD_PAGE_PROGRAM && !wr_protect_i) begin
                            st_ff <= ST_BUSY;
                            kind_ff <= K_QUAD;
                            timer_ff <= PP_CYC[23:0];
                            walk_ff <= 9'h000;
                            write_in_progress_bit_o <= 1'b1;
                        end
                    end
                end
                ST_BUSY: begin
                    // wait for the timer, the buffer walk and the drained fifo
                    if (timer_ff == `FS_TIMER_ZERO && walk_ff == `FS_WALK_END && !fifo_out_valid && !arr_valid_o) begin
                        st_ff <= ST_STANDBY;
                        write_in_progress_bit_o <= 1'b0;
                        write_latch_bit_o <= 1'b0;
                    end
                end
                ST_SLEEP_ENTRY: begin
                    if (timer_ff == `FS_TIMER_ZERO) begin
                        st_ff <= ST_SLEEP;
                        deep_sleep_o <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (cs_rise && done_ff && op_ff == `FS_OP_WAKE_SIGNATURE) begin
                        st_ff <= ST_WAKE;
                        timer_ff <= WK_CYC[23:0];
                    end
                end
                ST_WAKE: begin
                    if (timer_ff == `FS_TIMER_ZERO) begin
                        st_ff <= ST_STANDBY;
                        deep_sleep_o <= 1'b0;
                    end
                end
                default: begin
                    st_ff <= ST_STANDBY;
                end
            endcase
        end
    end

    // quad program data leaves through the fifo; a slow array stalls the walk
    fs_fifo #(
        .W(`FS_FIFO_W),
        .D(`FS_FIFO_D),
        .AW(`FS_FIFO_AW)
    ) u_prog_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(q_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i({addr_ff[23:8], widx, pg_buf[widx]}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );
endmodule
`default_nettype wire

// [include/fs_flash_map.vh]
// constants for the serial flash sequencer: opcodes, address fields, timing
// assumes a 40 MHz core clock sampling the host's serial pins
`ifndef FS_FLASH_MAP_VH
`define FS_FLASH_MAP_VH
// command codes
`define FS_OP_SET_WRITE_LATCH 8'h06
`define FS_OP_READ_STATUS 8'h05
`define FS_OP_QUAD_PAGE_PROGRAM 8'h32
`define FS_OP_SECREG_ERASE 8'h44
`define FS_OP_SECREG_PROGRAM 8'h42
`define FS_OP_SECREG_READ 8'h48
`define FS_OP_DEEP_SLEEP 8'hb9
`define FS_OP_WAKE_SIGNATURE 8'hab
// value is arbitrary, stands in for the part's signature byte
`define FS_SIGNATURE 8'h5a
// synchroniser vector layout
`define FS_PIN_SCLK 5
`define FS_PIN_CS 4
`define FS_SYNC_W 6
`define FS_SYNC_RST 6'h30
// bit counts within a frame phase
`define FS_CNT_ZERO 5'h00
`define FS_CNT_ONE 5'h01
`define FS_CNT_QUAD 5'h04
`define FS_CNT_BYTE_LAST 5'h07
`define FS_CNT_ADDR_LAST 5'h17
`define FS_OBIT_LAST 3'h7
// security register address fields
`define FS_SEC_TOP 8'h00
`define FS_SEC_MID 3'h0
`define FS_SEC_REG1 4'h1
`define FS_SEC_REG3 4'h3
`define FS_SEC_WORDS 768
`define FS_ERASED 8'hff
// page walk
`define FS_PAGE_WORDS 256
`define FS_WALK_END 9'h100
`define FS_WALK_ONE 9'h001
`define FS_ADDR_ONE 9'h001
// status byte
`define FS_STATUS_PAD 6'h00
// program buffer fifo
`define FS_FIFO_W 32
`define FS_FIFO_D 16
`define FS_FIFO_AW 4
// timing
`define FS_CLK_NS 25
`define FS_T_SECTOR_ERASE_NS 300000000
`define FS_T_PAGE_PROGRAM_NS 2000000
`define FS_T_SLEEP_ENTRY_NS 3000
`define FS_T_WAKE_NS 8000
`define FS_TIMER_ZERO 24'h000000
`define FS_TIMER_ONE 24'h000001
`endif

// [rtl/fs_fifo.v]
// synchronous fifo with valid/ready on both sides
// assumes a single clock; ce_i low freezes all state
`default_nettype none
module fs_fifo #(
    parameter W = 32,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    wire [AW:0] used;
    wire push;
    wire pop;

    assign used = wr_ff - rd_ff;
    assign in_ready_o = (used != D[AW:0]);
    assign out_valid_o = (used != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ff[AW-1:0]];
    assign push = ce_i & in_valid_i & in_ready_o;
    assign pop = ce_i & out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// [bench/fs_seq_sva.sv]
// port checker for the flash sequencer
// assumes bind onto fs_flash_seq, one clock domain
`default_nettype none
module fs_seq_sva (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire sclk_i,
    input wire cs_b_i,
    input wire [3:0] serial_io_lines_i,
    input wire [3:0] serial_io_lines_o,
    input wire [3:0] serial_io_lines_oe_o,
    input wire quad_io_enable_bit_i,
    input wire [2:0] secreg_lock_bits_i,
    input wire wr_protect_i,
    input wire write_in_progress_bit_o,
    input wire write_latch_bit_o,
    input wire deep_sleep_o,
    input wire arr_valid_o,
    input wire [23:0] arr_addr_o,
    input wire [7:0] arr_data_o,
    input wire arr_ready_i
);
timeunit 1ns;
timeprecision 100ps;
logic [8:0] hi_cnt_ff;
// counts select-high cycles, saturating so long idles stay legal
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        hi_cnt_ff <= 9'h000;
    end else if (!cs_b_i) begin
        hi_cnt_ff <= 9'h000;
    end else if (hi_cnt_ff != 9'h1ff) begin
        hi_cnt_ff <= hi_cnt_ff + 9'h001;
    end
end
default clocking cb @(posedge clk_i);
endclocking
default disable iff (!rst_b_i);
a_so_only_line: assert property (serial_io_lines_oe_o[3:2] == 2'h0 && !serial_io_lines_oe_o[0])
    else $error("output enable on a line other than the data out line");
a_oe_idle_off: assert property (cs_b_i [*7] |-> !serial_io_lines_oe_o[1])
    else $error("data out still driven while deselected");
a_wip_latch_clr: assert property ($fell(write_in_progress_bit_o) |-> !write_latch_bit_o)
    else $error("write latch kept after cycle end");
a_wip_needs_latch: assert property ($rose(write_in_progress_bit_o) |-> $past(write_latch_bit_o))
    else $error("cycle started without write latch");
a_wip_after_sel: assert property ($rose(write_in_progress_bit_o) |-> cs_b_i)
    else $error("cycle started while selected");
a_sleep_entry_wait: assert property ($rose(deep_sleep_o) |-> hi_cnt_ff >= 9'h070)
    else $error("sleep entered before entry delay");
a_wake_wait: assert property ($fell(deep_sleep_o) |-> hi_cnt_ff >= 9'h130)
    else $error("wake finished before wake delay");
a_sleep_not_busy: assert property (deep_sleep_o |-> !write_in_progress_bit_o && !arr_valid_o)
    else $error("activity while asleep");
a_arr_hold: assert property (arr_valid_o && !arr_ready_i |=> arr_valid_o && $stable(arr_addr_o) && $stable(arr_data_o))
    else $error("array request dropped or changed while stalled");
endmodule
`default_nettype wire

// [bench/fs_host.sv]
// host serial master model: select framing, serial clock idles high
// assumes tasks are entered right after a clk_i rising edge
`default_nettype none
module fs_host (
    input wire logic clk_i,
    input wire logic so_i,
    output logic sclk_o,
    output logic cs_b_o,
    output logic [3:0] io_o
);
timeunit 1ns;
timeprecision 100ps;
initial begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    io_o = 4'h0;
end
// one serial clock of eight core cycles; reply taken late, where it has settled
task automatic clk4(input logic [3:0] v, output logic s);
    sclk_o <= 1'b0;
    io_o <= v;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    s = so_i;
endtask
task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
        clk4({{3{~b[i]}}, b[i]}, r[i]);
    end
endtask
task automatic qb(input logic [7:0] b);
    logic d;
    clk4(b[7:4], d);
    clk4(b[3:0], d);
endtask
task automatic start();
    cs_b_o <= 1'b0;
    repeat (2) @(posedge clk_i);
endtask
// released lines show the inverse of their last value
task automatic stop(input int gap);
    cs_b_o <= 1'b1;
    io_o <= ~io_o;
    repeat (gap) @(posedge clk_i);
endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// top bench: host model, stalling array sink and checker around the sequencer
// assumes short self-timed counts set through the top parameters
`default_nettype none
`include "fs_flash_map.vh"
module tb_top;
timeunit 1ns;
timeprecision 100ps;
logic clk_i = 1'b0;
logic rst_b;
logic ce;
logic qe;
logic wp;
logic rdy = 1'b0;
logic tog = 1'b0;
logic [2:0] lock;
logic [7:0] s;
logic [7:0] exp_rd[4] = '{8'ha5, 8'h3c, 8'hc3, 8'hff};
logic [31:0] wq[$];
wire sclk, cs_b, write_in_progress_bit, latch, sleep, av;
wire [3:0] hio, dio, doe, io_w;
wire [23:0] aa;
wire [7:0] ad;
int bad_count = 0;
int checks = 0;
assign io_w = (doe & dio) | (~doe & hio);
always #12.5 clk_i = ~clk_i;
always @(posedge clk_i) begin
    tog <= ~tog;
    rdy <= ~rdy;
    if (av && rdy) begin
        wq.push_back({aa, ad});
    end
end
fs_host host (.clk_i(clk_i), .so_i(doe[1] ? dio[1] : tog), .sclk_o(sclk), .cs_b_o(cs_b), .io_o(hio));
fs_flash_seq #(.SE_CYC(400), .PP_CYC(300)) dut (.clk_i(clk_i), .rst_b_i(rst_b), .ce_i(ce), .sclk_i(sclk),
    .cs_b_i(cs_b), .serial_io_lines_i(io_w), .serial_io_lines_o(dio), .serial_io_lines_oe_o(doe),
    .quad_io_enable_bit_i(qe), .secreg_lock_bits_i(lock), .wr_protect_i(wp), .write_in_progress_bit_o(write_in_progress_bit),
    .write_latch_bit_o(latch), .deep_sleep_o(sleep), .arr_valid_o(av), .arr_addr_o(aa), .arr_data_o(ad),
    .arr_ready_i(rdy));
task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
endtask
task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
task automatic fr(input logic [7:0] o, input logic [23:0] a, input int n);
    logic [7:0] d;
    host.start();
    host.xb(o, d);
    for (int i = n - 1; i >= 0; i--) begin
        host.xb(a[8*i +: 8], d);
    end
endtask
task automatic op(input logic [7:0] o);
    fr(o, 24'h0, 0);
    host.stop(12);
endtask
task automatic st();
    fr(8'h05, 24'h0, 0);
    host.xb(8'h00, s);
    host.stop(12);
endtask
// bounded wait for the self-timed cycle to finish
task automatic idle();
    int n;
    for (n = 0; n < 3000 && write_in_progress_bit !== 1'b0; n++) begin
        @(posedge clk_i);
    end
    if (n == 3000) begin
        bad_count++;
        final_report();
    end
endtask
initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    qe = 1'b0;
    wp = 1'b0;
    lock = 3'h0;
    repeat (2) @(posedge clk_i);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("latch", latch, 0);
    chk("sleep", sleep, 0);
    host.start();
    host.stop(150);
    chk("sleep", sleep, 0);
    fr(8'h44, 24'h001000, 3);
    host.stop(12);
    st();
    chk("status", s, 8'h00);
    op(8'h06);
    fr(8'h44, 24'h001000, 3);
    host.stop(8);
    chk("wip", write_in_progress_bit, 1);
    st();
    chk("status", s, 8'h03);
    idle();
    chk("latch", latch, 0);
    op(8'h06);
    fr(8'h42, 24'h0011fe, 3);
    host.xb(8'ha5, s);
    host.xb(8'h3c, s);
    host.xb(8'hc3, s);
    host.stop(8);
    chk("wip", write_in_progress_bit, 1);
    idle();
    fr(8'h48, 24'h0011fe, 3);
    host.xb(8'h00, s);
    for (int i = 0; i < 4; i++) begin
        host.xb(8'h00, s);
        chk("read", s, exp_rd[i]);
    end
    host.stop(12);
    lock <= 3'h2;
    op(8'h06);
    fr(8'h42, 24'h002000, 3);
    host.xb(8'h00, s);
    host.stop(8);
    chk("wip", write_in_progress_bit, 0);
    qe <= 1'b1;
    op(8'h06);
    // protected target: frame runs to the end but no cycle starts
    wp <= 1'b1;
    fr(8'h32, 24'h012345, 3);
    host.qb(8'hff);
    host.stop(8);
    chk("wip", write_in_progress_bit, 0);
    wp <= 1'b0;
    fr(8'h32, 24'h012345, 3);
    host.qb(8'h12);
    host.qb(8'h34);
    host.stop(8);
    idle();
    chk("count", wq.size(), 2);
    chk("byte0", wq[0], 32'h01234512);
    chk("byte1", wq[1], 32'h01234634);
    op(8'hb9);
    // frozen clock enable must hold the entry timer
    ce <= 1'b0;
    repeat (200) @(posedge clk_i);
    chk("sleep", sleep, 0);
    ce <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("sleep", sleep, 1);
    op(8'h06);
    chk("latch", latch, 0);
    fr(8'hab, 24'h0, 3);
    for (int i = 0; i < 2; i++) begin
        host.xb(8'h00, s);
        chk("sig", s, `FS_SIGNATURE);
    end
    host.stop(400);
    chk("sleep", sleep, 0);
    op(8'hb9);
    repeat (200) @(posedge clk_i);
    // select rising mid-address must not wake
    fr(8'hab, 24'h0, 1);
    host.stop(400);
    chk("sleep", sleep, 1);
    op(8'hab);
    repeat (400) @(posedge clk_i);
    chk("sleep", sleep, 0);
    op(8'hb9);
    repeat (200) @(posedge clk_i);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("sleep", sleep, 0);
    final_report();
end
endmodule
bind fs_flash_seq fs_seq_sva chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .sclk_i(sclk_i),
    .cs_b_i(cs_b_i), .serial_io_lines_i(serial_io_lines_i), .serial_io_lines_o(serial_io_lines_o),
    .serial_io_lines_oe_o(serial_io_lines_oe_o), .quad_io_enable_bit_i(quad_io_enable_bit_i),
    .secreg_lock_bits_i(secreg_lock_bits_i), .wr_protect_i(wr_protect_i),
    .write_in_progress_bit_o(write_in_progress_bit_o), .write_latch_bit_o(write_latch_bit_o),
    .deep_sleep_o(deep_sleep_o), .arr_valid_o(arr_valid_o), .arr_addr_o(arr_addr_o),
    .arr_data_o(arr_data_o), .arr_ready_i(arr_ready_i));
`default_nettype wire
